/* File: design/ssc_top.sv */
`timescale 1ns/1ps
// Setup-mode string command handler
module ssc_top
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Received host bytes (already on clk)
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic setup_mode,
    // Timing settings
    input wire logic [7:0] delay_ms,
    input wire logic [7:0] preamble_bit_count,
    // Reply to host
    output logic host_valid,
    output logic [7:0] host_data,
    // Auxiliary serial output byte stream
    output logic aux_valid,
    output logic [7:0] aux_data,
    // Radio side
    output logic tx_key,
    output logic tx_preamble,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic cmd_done,
    output logic cmd_error
);
    ssc_state_type state; // Parser state
    logic [7:0] buf_mem [PKT_MAX]; // Transient packet buffer
    logic [4:0] buf_len; // Bytes expected
    logic [4:0] wr_idx; // Bytes collected
    logic [4:0] rd_idx; // Bytes handed on
    logic [4:0] aux_cnt; // Aux bytes forwarded
    logic [4:0] hex_val; // Decoded digit, bit 4 = invalid
    logic done_seq; // Sequencer finished
    ssc_byte_if pkt ();

    // Hex digit decode, 0-9 and A-F or a-f
    always_comb begin
        hex_val = 5'h10;
        if (rx_data >= 8'h30 && rx_data <= 8'h39) begin
            hex_val = {1'b0, rx_data[3:0]};
        end else if ((rx_data | 8'h20) >= 8'h61 && (rx_data | 8'h20) <= 8'h66) begin
            hex_val = {1'b0, rx_data[3:0] + 4'h9};
        end
    end

    // Command parser
    always_ff @(posedge clk) begin
        host_valid <= 1'b0;
        aux_valid <= 1'b0;
        cmd_error <= 1'b0;
        if (rst) begin
            state <= SSC_IDLE;
            buf_len <= '0;
            wr_idx <= '0;
            aux_cnt <= '0;
            host_data <= '0;
            aux_data <= '0;
        end else begin
            unique case (state)
                SSC_IDLE: if (rx_valid && setup_mode) begin
                    if (rx_data == CH_OPEN) begin
                        state <= SSC_AUX;
                        aux_cnt <= '0;
                    end else if (rx_data == CH_DOLLAR) begin
                        state <= SSC_LEN;
                    end
                end
                SSC_AUX: if (rx_valid) begin
                    if (rx_data == CH_CLOSE) begin
                        state <= SSC_IDLE;
                    end else if (rx_data == CH_CR) begin
                        aux_valid <= 1'b1;
                        aux_data <= CH_CR;
                        state <= SSC_IDLE;
                    end else if (aux_cnt < 5'(AUX_MAX)) begin
                        aux_valid <= 1'b1;
                        aux_data <= rx_data;
                        aux_cnt <= aux_cnt + 5'h01;
                    end
                end
                SSC_LEN: if (rx_valid) begin
                    if (hex_val[4]) begin
                        state <= SSC_IDLE;
                        cmd_error <= 1'b1;
                    end else begin
                        buf_len <= hex_val + 5'h01;
                        wr_idx <= '0;
                        host_valid <= 1'b1;
                        host_data <= CH_COLON;
                        state <= SSC_DATA;
                    end
                end
                SSC_DATA: if (rx_valid) begin
                    wr_idx <= wr_idx + 5'h01;
                    if (wr_idx + 5'h01 == buf_len) begin
                        state <= SSC_SEND;
                    end
                end
                SSC_SEND: if (done_seq) begin
                    state <= SSC_IDLE;
                end
                default: state <= SSC_IDLE;
            endcase
        end
    end

    // Buffer writes, one entry per data byte
    always_ff @(posedge clk) begin
        if (state == SSC_DATA && rx_valid) begin
            buf_mem[wr_idx[3:0]] <= rx_data;
        end
    end

    // Read pointer into the buffer for the sequencer
    always_ff @(posedge clk) begin
        if (rst || state != SSC_SEND) begin
            rd_idx <= '0;
        end else if (pkt.valid && pkt.ready) begin
            rd_idx <= rd_idx + 5'h01;
        end
    end

    assign pkt.valid = (state == SSC_SEND) && (rd_idx < buf_len);
    assign pkt.data = buf_mem[rd_idx[3:0]];
    assign pkt.last = (rd_idx + 5'h01 == buf_len);

    // Done pulse registered for the top-level output
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_done <= 1'b0;
        end else begin
            cmd_done <= done_seq;
        end
    end

    // Radio sequencer
    ssc_tx_seq u_seq (
        .clk(clk),
        .rst(rst),
        .delay_ms(delay_ms),
        .preamble_bit_count(preamble_bit_count),
        .pkt(pkt),
        .tx_key(tx_key),
        .tx_preamble(tx_preamble),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_ready(tx_ready),
        .done(done_seq)
    );
endmodule : ssc_top

/* File: design/ssc_pkg.sv */
// Overview of operation
// - Brackets 91/93 frame a 1-30 byte string
// - Forward only bytes inside the brackets
// - Carriage return close appends byte 13
// - Dollar 36, length digit, 1-16 data bytes
// - Hex length digit, buffer is value+1
// - Colon 58 returned after length digit
// - Collect length+1 bytes, then transmit packet
// - After packet, return to setup mode
// - Sustain 4800 baud streaming without overflow
// - Default latency about 110 ms
// - Acknowledge burst takes about 20 ms
// - Preamble bits 620 us, default 80 bits; the code loads no default, the count always comes from preamble_bit_count
// - Initial delay before keying, default 20 ms; the code loads no default, the delay always comes from delay_ms
package ssc_pkg;
    // System clock
    localparam int CLK_HZ = 40000000;
    // Character codes
    localparam logic [7:0] CH_OPEN = 8'h5b;
    localparam logic [7:0] CH_CLOSE = 8'h5d;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_COLON = 8'h3a;
    // String limits
    localparam int AUX_MAX = 30;
    localparam int PKT_MAX = 16;
    // Default timing
    localparam int DELAY_MS = 20;
    localparam int PREAMBLE_BIT_US = 620;
    localparam logic [7:0] PREAMBLE_BITS_RESET = 8'h50;
    localparam logic [7:0] DELAY_RESET = 8'h14;
    // Cycles per millisecond and per preamble bit (rounded up, least times)
    localparam int MS_CYCLES = (CLK_HZ + 999) / 1000;
    localparam int PBIT_CYCLES = (CLK_HZ / 1000 * PREAMBLE_BIT_US + 999) / 1000;
    // Serial bit time at 4800 baud
    localparam int BAUD = 4800;
    // Expected single-byte latency and acknowledge burst air time
    localparam int LATENCY_MS = 110;
    localparam int ACK_BURST_MS = 20;
    localparam int BIT_CYCLES = CLK_HZ / BAUD;
    // Parser states
    typedef enum logic [2:0] {
        SSC_IDLE, SSC_AUX, SSC_LEN, SSC_DATA, SSC_SEND
    } ssc_state_type;
endpackage : ssc_pkg

/* File: design/ssc_byte_if.sv */
`timescale 1ns/1ps
// Byte handshake between parser and transmit sequencer
interface ssc_byte_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    logic last;
    modport source (output valid, output data, output last, input ready);
    modport sink (input valid, input data, input last, output ready);
endinterface : ssc_byte_if

/* File: design/ssc_tx_seq.sv */
`timescale 1ns/1ps
// Radio transmit sequencer: delay, preamble, then packet bytes
module ssc_tx_seq
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Timing settings
    input wire logic [7:0] delay_ms,
    input wire logic [7:0] preamble_bit_count,
    // Packet bytes from the parser
    ssc_byte_if.sink pkt,
    // Radio side
    output logic tx_key,
    output logic tx_preamble,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic done
);
    typedef enum logic [1:0] {SSC_T_IDLE, SSC_T_DLY, SSC_T_PRE, SSC_T_DAT} ssc_t_type;
    ssc_t_type st; // Sequencer state
    logic [31:0] cnt; // Cycle counter
    logic [7:0] units; // Milliseconds or preamble bits left
    logic last_in; // Final payload byte sits in the output register

    // Accept bytes only while streaming the payload
    // Nothing more is taken once the final byte waits for the radio
    assign pkt.ready = (st == SSC_T_DAT) && !last_in && (!tx_valid || tx_ready);

    // Sequence: wait delay from last byte collected, send preamble, stream data
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (rst) begin
            st <= SSC_T_IDLE;
            cnt <= '0;
            units <= '0;
            tx_key <= 1'b0;
            tx_preamble <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= '0;
            last_in <= 1'b0;
        end else begin
            unique case (st)
                SSC_T_IDLE: if (pkt.valid) begin
                    st <= SSC_T_DLY;
                    units <= delay_ms;
                    cnt <= '0;
                end
                SSC_T_DLY: if (units == 8'h00) begin
                    tx_key <= 1'b1;
                    units <= preamble_bit_count;
                    cnt <= '0;
                    if (preamble_bit_count == 8'h00) begin
                        st <= SSC_T_DAT; // No preamble programmed
                    end else begin
                        st <= SSC_T_PRE;
                        tx_preamble <= 1'b1;
                    end
                end else if (cnt == 32'(MS_CYCLES - 1)) begin
                    cnt <= '0;
                    units <= units - 8'h01;
                end else begin
                    cnt <= cnt + 32'h1;
                end
                SSC_T_PRE: if (cnt == 32'(PBIT_CYCLES - 1)) begin
                    cnt <= '0;
                    units <= units - 8'h01;
                    // Leave exactly at the end of the last bit time
                    if (units == 8'h01) begin
                        st <= SSC_T_DAT;
                        tx_preamble <= 1'b0;
                    end
                end else begin
                    cnt <= cnt + 32'h1;
                end
                SSC_T_DAT: begin
                    // Radio took the held byte
                    if (tx_valid && tx_ready) begin
                        tx_valid <= 1'b0;
                        // Unkey only after the final byte is gone
                        if (last_in) begin
                            st <= SSC_T_IDLE;
                            tx_key <= 1'b0;
                            last_in <= 1'b0;
                            done <= 1'b1;
                        end
                    end
                    if (pkt.valid && pkt.ready) begin
                        tx_valid <= 1'b1;
                        tx_data <= pkt.data;
                        last_in <= pkt.last;
                    end
                end
            endcase
        end
    end
endmodule : ssc_tx_seq

/* File: tb/ssc_top_asserts.sv */
`timescale 1ns/1ps
// Port checker for the string command handler
module ssc_top_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire logic rx_valid,
    input wire logic host_valid,
    input wire logic [7:0] host_data,
    input wire logic aux_valid,
    input wire logic tx_key,
    input wire logic tx_preamble,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic cmd_done,
    input wire logic cmd_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_colon; host_valid |-> host_data == 8'h3a; endproperty
    a_colon: assert property (p_colon) else $error("reply is not a colon");
    property p_reply_cause; host_valid |-> $past(rx_valid); endproperty
    a_reply_cause: assert property (p_reply_cause) else $error("reply without byte");
    property p_aux_cause; aux_valid |-> $past(rx_valid); endproperty
    a_aux_cause: assert property (p_aux_cause) else $error("aux byte without input");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    a_hold: assert property (p_hold) else $error("payload byte dropped");
    property p_keyed; tx_valid || tx_preamble |-> tx_key; endproperty
    a_keyed: assert property (p_keyed) else $error("sending while unkeyed");
    property p_bad; cmd_error |-> !tx_key ##1 !tx_key; endproperty
    a_bad: assert property (p_bad) else $error("keyed after bad digit");
    property p_done; $fell(tx_key) && !$past(rst) |-> ##[0:1] cmd_done; endproperty
    a_done: assert property (p_done) else $error("packet end not flagged");
    property p_pulse; cmd_done |=> !cmd_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than a cycle");
endmodule : ssc_top_asserts
bind ssc_top ssc_top_asserts i_ssc_top_asserts (.clk(clk), .rst(rst), .rx_valid(rx_valid),
    .host_valid(host_valid), .host_data(host_data), .aux_valid(aux_valid), .tx_key(tx_key),
    .tx_preamble(tx_preamble), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .cmd_done(cmd_done), .cmd_error(cmd_error));

/* File: tb/ssc_host_model.sv */
`timescale 1ns/1ps
// Host computer sending characters, one byte per pulse
module ssc_host_model (
    // Clock
    input wire logic clk,
    // Bytes toward the block
    output logic rx_valid,
    output logic [7:0] rx_data
);
    initial rx_valid = 1'b0;
    initial rx_data = 8'h00;
    // Bursts stay short, so no flow control is watched
    // One byte; the data line shows the inverse once released
    task automatic send(logic [7:0] b);
        @(posedge clk);
        #2 rx_valid = 1'b1;
        rx_data = b;
        @(posedge clk);
        #2 rx_valid = 1'b0;
        rx_data = ~b;
    endtask : send
endmodule : ssc_host_model

/* File: tb/ssc_top_tb.sv */
`timescale 1ns/1ps
// Testbench for the string command handler
module ssc_top_tb;
    import ssc_pkg::*;
    logic clk = 0, rst = 1, setup_mode = 1, tx_ready = 0, rx_valid;
    logic host_valid, aux_valid, tx_key, tx_preamble, tx_valid, cmd_done, cmd_error;
    logic [7:0] rx_data, host_data, aux_data, tx_data;
    logic [7:0] dly = 8'h00, pbits = 8'h01;
    logic [7:0] auxq[$], txq[$];
    int fails = 0, checks_done = 0, colons = 0, errs = 0, dones = 0, pre = 0;
    initial forever #12.5 clk = ~clk;
    // Radio side stalls every other cycle
    always @(posedge clk) #2 tx_ready = ~tx_ready;
    // Output monitor
    always @(posedge clk) begin
        if (aux_valid === 1'b1) auxq.push_back(aux_data);
        if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_data);
        colons += (host_valid === 1'b1 && host_data === 8'h3a);
        errs += (cmd_error === 1'b1);
        dones += (cmd_done === 1'b1);
        pre += (tx_preamble === 1'b1);
    end
    ssc_host_model i_ssc_host_model (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data));
    ssc_top i_ssc_top (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
        .setup_mode(setup_mode), .delay_ms(dly), .preamble_bit_count(pbits),
        .host_valid(host_valid), .host_data(host_data), .aux_valid(aux_valid),
        .aux_data(aux_data), .tx_key(tx_key), .tx_preamble(tx_preamble), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .cmd_done(cmd_done), .cmd_error(cmd_error));
    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Sends a string, then compares the aux stream
    task automatic aux_str(string s, string exp);
        auxq = {};
        foreach (s[i]) i_ssc_host_model.send(s[i]);
        repeat (3) @(posedge clk);
        chk("aux_len", auxq.size(), exp.len());
        foreach (exp[i]) chk("aux_byte", auxq[i], exp[i]);
    endtask : aux_str
    // Transmit command with n data bytes, dm ms delay and pb preamble bits
    task automatic tx_cmd(logic [7:0] dig, int n, logic [7:0] dm, logic [7:0] pb);
        int w;
        int lo;
        w = 0;
        lo = int'(dm) * MS_CYCLES;
        txq = {};
        colons = 0;
        dones = 0;
        pre = 0;
        @(posedge clk);
        #2 dly = dm;
        pbits = pb;
        i_ssc_host_model.send(8'h24);
        i_ssc_host_model.send(dig);
        repeat (2) @(posedge clk);
        chk("colon", colons, 1);
        for (int i = 0; i < n; i++) i_ssc_host_model.send(8'h30 + i);
        // Key-up follows the last byte after the programmed delay
        while (tx_key !== 1'b1 && w < 60000) begin
            @(posedge clk);
            w++;
        end
        chk("delay", (w >= lo && w <= lo + 4), 1'b1);
        while (dones == 0 && w < 60000) begin
            @(posedge clk);
            w++;
        end
        chk("done", dones, 1);
        chk("preamble", pre, int'(pb) * PBIT_CYCLES);
        chk("tx_len", txq.size(), n);
        foreach (txq[i]) chk("tx_byte", txq[i], 8'h30 + i);
    endtask : tx_cmd
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        #2 rst = 0;
        aux_str("[AB]", "AB");
        aux_str("[x\015", "x\015");
        #2 setup_mode = 0;
        aux_str("[k]", "");
        #2 setup_mode = 1;
        tx_cmd("3", 4, 8'h00, 8'h01);
        aux_str("[q]", "q");
        tx_cmd("F", 16, 8'h01, 8'h00);
        errs = 0;
        aux_str("$g", "");
        chk("error", errs, 1);
        chk("key", tx_key, 1'b0);
        aux_str("[z]", "z");
        print_verdict();
    end
    // Watchdog
    initial begin
        #2400us;
        fails++;
        print_verdict();
    end
endmodule : ssc_top_tb
